// *** rtl/bsc_boot_clock.sv ***
// Local design decision: the AXI4-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module bsc_boot_clock
  import bsc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [3:0] boot_sel,
  input wire logic fetch_valid,
  input wire logic [31:0] fetch_addr,
  output logic usb_device_clock_gate,
  output logic dma_clock_enable,
  output logic [1:0] spare_ctrl,
  output logic boot_rom_clock_force,
  output logic boot_rom_clock_enable,
  output logic boot_valid,
  output logic [3:0] boot_code,
  output bsc_cfg_t boot_cfg,
  output logic [31:0] reset_vector,
  output logic map_valid,
  output logic [31:0] map_addr,
  output bsc_target_t map_target,
  output logic map_blocked
);

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers

  function automatic bsc_cfg_t decode_boot(input logic [3:0] code);
    bsc_cfg_t c;
    c = '{BSC_TGT_NONE, BSC_W32, BSC_LANE_ALL, 1'b0, 1'b0};
    unique case (code)
      BSC_CODE_ROM: begin
        c.target = BSC_TGT_ROM;
        c.rom_visible = 1'b1;
      end
      BSC_CODE_SF16: begin
        c.target = BSC_TGT_SDCS1;
        c.width = BSC_W16;
        c.lane = BSC_LANE_LOW;
      end
      BSC_CODE_SF32: begin
        c.target = BSC_TGT_SDCS1;
      end
      BSC_CODE_CS8: begin
        c.target = BSC_TGT_CS0;
        c.width = BSC_W8;
        c.lane = BSC_LANE_LOW;
      end
      BSC_CODE_CS16H: begin
        c.target = BSC_TGT_CS0;
        c.width = BSC_W16;
        c.lane = BSC_LANE_HIGH;
      end
      BSC_CODE_CS16L: begin
        c.target = BSC_TGT_CS0;
        c.width = BSC_W16;
        c.lane = BSC_LANE_LOW;
      end
      BSC_CODE_CS32: begin
        c.target = BSC_TGT_CS0;
      end
      default: begin
        // 0111 and every code with the top pin high map nothing
        c.reserved = 1'b1;
      end
    endcase
    return c;
  endfunction

  function automatic logic reg_hit(input logic [31:0] addr);
    return addr[31:2] == BSC_GCG_OFFSET[31:2];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // boot select capture

  typedef enum logic [1:0] {
    BSC_CAP_SETTLE,
    BSC_CAP_SAMPLE,
    BSC_CAP_HELD
  } bsc_cap_t;

  logic [3:0] sync1;
  logic [3:0] sync2;
  logic [3:0] sync3;
  bsc_cap_t cap_state;
  bsc_cap_t next_cap_state;
  logic [1:0] settle_cnt;
  logic [1:0] next_settle_cnt;
  logic next_boot_valid;
  logic [3:0] next_boot_code;
  bsc_cfg_t next_boot_cfg;

  always_comb begin
    next_cap_state = cap_state;
    next_settle_cnt = settle_cnt;
    next_boot_valid = boot_valid;
    next_boot_code = boot_code;
    next_boot_cfg = boot_cfg;
    unique case (cap_state)
      BSC_CAP_SETTLE: begin
        // chain must be refilled from the pins before any sample counts
        next_settle_cnt = settle_cnt + 2'h1;
        if (settle_cnt == BSC_SETTLE - 2'h1) begin
          next_cap_state = BSC_CAP_SAMPLE;
        end
      end
      BSC_CAP_SAMPLE: begin
        if (sync2 == sync3) begin
          next_boot_code = sync3;
          next_boot_cfg = decode_boot(sync3);
          next_boot_valid = 1'b1;
          next_cap_state = BSC_CAP_HELD;
        end
      end
      BSC_CAP_HELD: begin
        // later pin motion is ignored; the board must not move them
        next_cap_state = BSC_CAP_HELD;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1 <= 4'h0;
      sync2 <= 4'h0;
      sync3 <= 4'h0;
      cap_state <= BSC_CAP_SETTLE;
      settle_cnt <= 2'h0;
      boot_valid <= 1'b0;
      boot_code <= 4'h0;
      boot_cfg <= '{BSC_TGT_NONE, BSC_W32, BSC_LANE_ALL, 1'b0, 1'b0};
      reset_vector <= BSC_RESET_VECTOR;
    end else begin
      sync1 <= boot_sel;
      sync2 <= sync1;
      sync3 <= sync2;
      cap_state <= next_cap_state;
      settle_cnt <= next_settle_cnt;
      boot_valid <= next_boot_valid;
      boot_code <= next_boot_code;
      boot_cfg <= next_boot_cfg;
      reset_vector <= BSC_RESET_VECTOR;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock control register and its write channel

  logic [4:0] ctrl;
  logic [4:0] next_ctrl;
  logic aw_full;
  logic next_aw_full;
  logic [31:0] aw_addr;
  logic [31:0] next_aw_addr;
  logic w_full;
  logic next_w_full;
  logic [31:0] w_data;
  logic [31:0] next_w_data;
  logic [3:0] w_strb;
  logic [3:0] next_w_strb;
  logic next_bvalid;
  logic [1:0] next_bresp;

  always_comb begin
    next_ctrl = ctrl;
    next_aw_full = aw_full;
    next_aw_addr = aw_addr;
    next_w_full = w_full;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_full = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_full = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (aw_full && w_full && !s_axi_bvalid) begin
      next_aw_full = 1'b0;
      next_w_full = 1'b0;
      next_bvalid = 1'b1;
      if (reg_hit(aw_addr)) begin
        next_bresp = BSC_RESP_OKAY;
        // only lane 0 holds live bits; upper bits have no storage
        if (w_strb[0]) begin
          next_ctrl = w_data[BSC_CTRL_W-1:0];
        end
      end else begin
        next_bresp = BSC_RESP_DECERR;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= BSC_CTRL_RESET;
      aw_full <= 1'b0;
      aw_addr <= 32'h00000000;
      w_full <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= BSC_RESP_OKAY;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      aw_full <= next_aw_full;
      aw_addr <= next_aw_addr;
      w_full <= next_w_full;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_awready <= !next_aw_full && !next_bvalid;
      s_axi_wready <= !next_w_full && !next_bvalid;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read channel

  logic next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;

  always_comb begin
    next_rvalid = s_axi_rvalid;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      if (reg_hit(s_axi_araddr)) begin
        next_rdata = {27'h0, ctrl};
        next_rresp = BSC_RESP_OKAY;
      end else begin
        next_rdata = 32'h00000000;
        next_rresp = BSC_RESP_DECERR;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= BSC_RESP_OKAY;
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
      s_axi_arready <= !next_rvalid;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock enables, registered so the gate cells see clean levels

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      usb_device_clock_gate <= 1'b1;
      dma_clock_enable <= 1'b1;
      spare_ctrl <= 2'h3;
      boot_rom_clock_force <= 1'b0;
      boot_rom_clock_enable <= 1'b0;
    end else begin
      usb_device_clock_gate <= next_ctrl[BSC_USB_BIT];
      dma_clock_enable <= next_ctrl[BSC_DMA_BIT];
      spare_ctrl <= next_ctrl[BSC_SPARE_HI_BIT:BSC_SPARE_LO_BIT];
      boot_rom_clock_force <= next_ctrl[BSC_ROMF_BIT];
      boot_rom_clock_enable <= next_ctrl[BSC_ROMF_BIT] ||
        next_boot_cfg.rom_visible;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // low megabyte alias; one cycle of latency on the fetch path

  logic next_map_valid;
  logic [31:0] next_map_addr;
  bsc_target_t next_map_target;
  logic next_map_blocked;
  logic low_page;

  always_comb begin
    low_page = fetch_addr[31:20] == BSC_ALIAS_PAGE;
    next_map_valid = fetch_valid;
    next_map_addr = fetch_addr;
    next_map_target = BSC_TGT_NONE;
    next_map_blocked = 1'b0;
    if (fetch_valid && boot_valid) begin
      if (low_page) begin
        next_map_target = boot_cfg.target;
        unique case (boot_cfg.target)
          BSC_TGT_ROM: begin
            next_map_addr = BSC_ROM_BASE | (fetch_addr & BSC_ALIAS_MASK);
          end
          BSC_TGT_SDCS1: begin
            next_map_addr = BSC_SDCS1_BASE | (fetch_addr & BSC_ALIAS_MASK);
          end
          BSC_TGT_CS0: begin
            next_map_addr = BSC_CS0_BASE | (fetch_addr & BSC_ALIAS_MASK);
          end
          BSC_TGT_NONE: begin
            next_map_blocked = 1'b1;
          end
        endcase
      end else if (fetch_addr[31:20] == BSC_ROM_BASE[31:20] &&
                   !boot_cfg.rom_visible) begin
        next_map_blocked = 1'b1;
      end
    end else if (fetch_valid) begin
      // nothing is decoded before the pins are captured
      next_map_blocked = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      map_valid <= 1'b0;
      map_addr <= 32'h00000000;
      map_target <= BSC_TGT_NONE;
      map_blocked <= 1'b0;
    end else begin
      map_valid <= next_map_valid;
      map_addr <= next_map_addr;
      map_target <= next_map_target;
      map_blocked <= next_map_blocked;
    end
  end

endmodule
`default_nettype wire

// *** pkg/bsc_pkg.sv ***
`default_nettype none
package bsc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register map
  localparam logic [31:0] BSC_GCG_OFFSET = 32'h0021b810;
  localparam int BSC_USB_BIT = 0;
  localparam int BSC_SPARE_LO_BIT = 1;
  localparam int BSC_SPARE_HI_BIT = 2;
  localparam int BSC_DMA_BIT = 3;
  localparam int BSC_ROMF_BIT = 4;
  localparam int BSC_CTRL_W = 5;
  localparam logic [4:0] BSC_CTRL_RESET = 5'h0f;
  localparam logic [1:0] BSC_RESP_OKAY = 2'h0;
  localparam logic [1:0] BSC_RESP_DECERR = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // boot select codes
  localparam logic [3:0] BSC_CODE_ROM = 4'h0;
  localparam logic [3:0] BSC_CODE_SF16 = 4'h1;
  localparam logic [3:0] BSC_CODE_SF32 = 4'h2;
  localparam logic [3:0] BSC_CODE_CS8 = 4'h3;
  localparam logic [3:0] BSC_CODE_CS16H = 4'h4;
  localparam logic [3:0] BSC_CODE_CS16L = 4'h5;
  localparam logic [3:0] BSC_CODE_CS32 = 4'h6;
  localparam logic [31:0] BSC_RESET_VECTOR = 32'h00000000;
  localparam logic [31:0] BSC_ALIAS_MASK = 32'h000fffff;
  localparam logic [11:0] BSC_ALIAS_PAGE = 12'h000;
  localparam logic [31:0] BSC_CS0_BASE = 32'h10000000;
  localparam logic [31:0] BSC_SDCS1_BASE = 32'h0c000000;
  localparam logic [31:0] BSC_ROM_BASE = 32'h00400000;
  localparam logic [1:0] BSC_SETTLE = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef enum logic [1:0] {
    BSC_TGT_NONE,
    BSC_TGT_ROM,
    BSC_TGT_SDCS1,
    BSC_TGT_CS0
  } bsc_target_t;

  typedef enum logic [1:0] {
    BSC_W8,
    BSC_W16,
    BSC_W32
  } bsc_width_t;

  typedef enum logic [1:0] {
    BSC_LANE_LOW,
    BSC_LANE_HIGH,
    BSC_LANE_ALL
  } bsc_lane_t;

  typedef struct packed {
    bsc_target_t target;
    bsc_width_t width;
    bsc_lane_t lane;
    logic rom_visible;
    logic reserved;
  } bsc_cfg_t;

endpackage
`default_nettype wire

// *** bench/bsc_boot_clock_monitor.sv ***
`timescale 1ns/100ps
`default_nettype none
module bsc_boot_clock_monitor
  import bsc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [31:0] fetch_addr,
  input wire logic usb_device_clock_gate,
  input wire logic dma_clock_enable,
  input wire logic boot_rom_clock_force,
  input wire logic boot_rom_clock_enable,
  input wire logic boot_valid,
  input wire logic [3:0] boot_code,
  input wire bsc_cfg_t boot_cfg,
  input wire logic [31:0] reset_vector,
  input wire logic map_valid,
  input wire logic [31:0] map_addr,
  input wire bsc_target_t map_target,
  input wire logic map_blocked
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  //////////////////////////////////////////////////////////////////////////
  AST_VEC: assert property (reset_vector == 32'h00000000)
    else $error("reset vector not zero");
  AST_ROMCLK: assert property (boot_valid |-> boot_rom_clock_enable ==
    (boot_rom_clock_force | (boot_code == 4'h0))) else $error("rom clock");
  AST_HOLD: assert property (boot_valid && $past(boot_valid) |->
    $stable(boot_code) && $stable(boot_cfg)) else $error("code moved");
  AST_ROM: assert property (map_valid && $past(boot_valid) &&
    boot_code == 4'h0 && $past(fetch_addr[31:20]) == 12'h000 |->
    map_target == BSC_TGT_ROM && !map_blocked) else $error("rom not mapped");
  AST_HIDE: assert property (map_valid && $past(boot_valid) &&
    boot_code != 4'h0 && $past(fetch_addr[31:20]) == 12'h004 |->
    map_blocked) else $error("rom visible");
  AST_ALIAS: assert property (map_valid && $past(boot_valid) &&
    $past(fetch_addr[31:20]) == 12'h000 && boot_cfg.target == BSC_TGT_CS0
    |-> map_addr == (BSC_CS0_BASE | {12'h000, $past(fetch_addr[19:0])}))
    else $error("alias address");
  AST_RDZERO: assert property (s_axi_rvalid |->
    s_axi_rdata[31:5] == 27'h0) else $error("upper bits set");
  AST_CS32: assert property (boot_valid && boot_code == 4'h6 |->
    boot_cfg.target == BSC_TGT_CS0 && boot_cfg.width == BSC_W32)
    else $error("code 6 config");
  AST_SF16: assert property (boot_valid && boot_code == 4'h1 |->
    boot_cfg.target == BSC_TGT_SDCS1 && boot_cfg.width == BSC_W16)
    else $error("code 1 config");
  // usb_device_clock_gate and dma_clock_enable may move only with a write completion
  AST_CLK: assert property (!s_axi_bvalid ##1 !s_axi_bvalid |->
    $stable(usb_device_clock_gate) && $stable(dma_clock_enable))
    else $error("clock enable moved");
endmodule
bind bsc_boot_clock bsc_boot_clock_monitor u_mon (.aclk, .aresetn,
  .s_axi_bvalid, .s_axi_rvalid, .s_axi_rdata, .fetch_addr,
  .usb_device_clock_gate, .dma_clock_enable, .boot_rom_clock_force,
  .boot_rom_clock_enable, .boot_valid, .boot_code, .boot_cfg,
  .reset_vector, .map_valid, .map_addr, .map_target, .map_blocked);
`default_nettype wire

// *** bench/bsc_pins_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module bsc_pins_model (
  input wire logic aclk,
  input wire logic [3:0] pin_code,
  output logic [3:0] boot_sel
);
  // straps settle one edge after the board moves them
  always_ff @(posedge aclk) begin
    boot_sel <= pin_code;
  end
endmodule
`default_nettype wire

// *** bench/tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
  $display("BAD %0t got %h exp %h", $time, g, e); end end
module tb_top
  import bsc_pkg::*;
;
  logic aclk = 1'b0, aresetn = 1'b0, fetch_valid = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0;
  logic [31:0] s_axi_araddr = 32'h0, fetch_addr = 32'h0;
  logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
  logic [3:0] s_axi_wstrb = 4'hf, pin_code = 4'h0, boot_sel, boot_code;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, usb_device_clock_gate, dma_clock_enable;
  logic boot_rom_clock_force, boot_rom_clock_enable, boot_valid;
  logic map_valid, map_blocked;
  logic [1:0] s_axi_bresp, s_axi_rresp, spare_ctrl, r;
  logic [31:0] s_axi_rdata, reset_vector, map_addr, d;
  bsc_cfg_t boot_cfg;
  bsc_target_t map_target;
  logic [4:0] en_bits;
  int n_fail = 0, n_compared = 0;
  bsc_target_t tg[8] = '{BSC_TGT_ROM, BSC_TGT_SDCS1, BSC_TGT_SDCS1,
    BSC_TGT_CS0, BSC_TGT_CS0, BSC_TGT_CS0, BSC_TGT_CS0, BSC_TGT_NONE};
  logic [31:0] bs[8] = '{BSC_ROM_BASE, BSC_SDCS1_BASE, BSC_SDCS1_BASE,
    BSC_CS0_BASE, BSC_CS0_BASE, BSC_CS0_BASE, BSC_CS0_BASE, 32'h0};
  bsc_width_t wd[8] = '{BSC_W32, BSC_W16, BSC_W32, BSC_W8, BSC_W16,
    BSC_W16, BSC_W32, BSC_W32};
  bsc_lane_t ln[8] = '{BSC_LANE_ALL, BSC_LANE_LOW, BSC_LANE_ALL,
    BSC_LANE_LOW, BSC_LANE_HIGH, BSC_LANE_LOW, BSC_LANE_ALL, BSC_LANE_ALL};
  //////////////////////////////////////////////////////////////////////////
  always #12.5 aclk = ~aclk;
  // register image rebuilt from the enable pins, bit 4 down to bit 0
  assign en_bits = {boot_rom_clock_force, dma_clock_enable, spare_ctrl,
    usb_device_clock_gate};
  bsc_pins_model u_pins (.aclk, .pin_code, .boot_sel);
  bsc_boot_clock u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .boot_sel, .fetch_valid, .fetch_addr,
    .usb_device_clock_gate, .dma_clock_enable, .spare_ctrl,
    .boot_rom_clock_force, .boot_rom_clock_enable, .boot_valid, .boot_code,
    .boot_cfg, .reset_vector, .map_valid, .map_addr, .map_target,
    .map_blocked);
  //////////////////////////////////////////////////////////////////////////
  task automatic summarize;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic hang;
    n_fail++;
    $display("BAD %0t wait ran out", $time);
    summarize;
  endtask
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] v);
    int n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 50);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n >= 50) hang;
  endtask
  task automatic axi_rd(input logic [31:0] a);
    int n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 50);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n >= 50) hang;
  endtask
  // map result stands one cycle, so look mid-cycle
  task automatic fetch(input logic [31:0] a);
    @(posedge aclk);
    fetch_valid <= 1'b1;
    fetch_addr <= a;
    @(posedge aclk);
    fetch_valid <= 1'b0;
    @(negedge aclk);
  endtask
  task automatic boot(input logic [3:0] c);
    int n = 0;
    @(posedge aclk);
    pin_code <= c;
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
    end while (!boot_valid && n < 20);
    if (n >= 20) hang;
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    for (int c = 0; c < 8; c++) begin
      boot(4'(c));
      `CHK(reset_vector, 32'h0)
      `CHK(boot_code, 4'(c))
      `CHK(boot_rom_clock_enable, c == 0)
      `CHK(boot_cfg.rom_visible, c == 0)
      if (c > 0 && c < 7) begin
        `CHK(boot_cfg.width, wd[c])
        `CHK(boot_cfg.lane, ln[c])
      end
      fetch(32'h00000100);
      `CHK(map_valid, 1'b1)
      `CHK(map_blocked, c == 7)
      if (c < 7) begin
        `CHK(map_target, tg[c])
        `CHK(map_addr, bs[c] | 32'h100)
      end
      fetch(BSC_ROM_BASE | 32'h10);
      if (c > 0) `CHK(map_blocked, 1'b1)
      else `CHK(map_blocked, 1'b0)
      // pins moved on purpose: capture must not follow
      @(posedge aclk);
      pin_code <= 4'(c) ^ 4'h5;
      repeat (5) @(posedge aclk);
      `CHK(boot_code, 4'(c))
      $display("boot code %0d done", c);
    end
    boot(4'h3);
    axi_rd(BSC_GCG_OFFSET);
    `CHK(d, 32'h0000000f)
    axi_wr(BSC_GCG_OFFSET, 32'hffffffff);
    `CHK(r, BSC_RESP_OKAY)
    `CHK(en_bits, 5'h1f)
    `CHK(boot_rom_clock_enable, 1'b1)
    axi_rd(BSC_GCG_OFFSET);
    `CHK(d, 32'h0000001f)
    axi_wr(BSC_GCG_OFFSET, 32'h0);
    `CHK(en_bits, 5'h00)
    `CHK(boot_rom_clock_enable, 1'b0)
    // lane 0 strobe low: register must keep its value
    s_axi_wstrb <= 4'he;
    axi_wr(BSC_GCG_OFFSET, 32'h1f);
    s_axi_wstrb <= 4'hf;
    `CHK(r, BSC_RESP_OKAY)
    `CHK(en_bits, 5'h00)
    axi_wr(BSC_GCG_OFFSET + 32'h4, 32'h1f);
    `CHK(r, BSC_RESP_DECERR)
    axi_rd(BSC_GCG_OFFSET + 32'h4);
    `CHK({r, d}, {BSC_RESP_DECERR, 32'h0})
    axi_rd(BSC_GCG_OFFSET);
    `CHK(d, 32'h0)
    $display("register tests done");
    summarize;
  end
endmodule
`default_nettype wire
